// *** menu_ctrl_pkg.sv ***
// constants, types and register map for the program-mode menu controller
package menu_ctrl_pkg;
  // timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 20;
  localparam int MS_W = 16;
  // hold and scroll times, in ms ticks
  localparam int ENTRY_HOLD_S = 10;
  localparam int ENTRY_HOLD_MS = ENTRY_HOLD_S * 1000;
  localparam int PROMPT_MS = 1000;
  localparam int ITEM_HOLD_S = 3;
  localparam int ITEM_HOLD_MS = PROMPT_MS + ITEM_HOLD_S * 1000;
  localparam int SAVE_HOLD_S = 3;
  localparam int SAVE_HOLD_MS = SAVE_HOLD_S * 1000;
  localparam int RANGE_HOLD_S = 2;
  localparam int RANGE_HOLD_MS = RANGE_HOLD_S * 1000;
  localparam int DEBOUNCE_MS = 20;
  localparam int TIMEOUT_S = 15;
  localparam int TIMEOUT_SCROLLS = 4;
  localparam int SCROLL_MS = TIMEOUT_S * 1000 / TIMEOUT_SCROLLS;
  localparam logic [3:0] STATUS_LAST = 4'hD;
  // setting limits and defaults
  localparam logic [7:0] SPAN_MIN_FULL = 8'h05;
  localparam logic [7:0] SPAN_MAX_FULL = 8'h5F;
  localparam logic [7:0] SPAN_MIN_HALF = 8'h02;
  localparam logic [7:0] SPAN_MAX_HALF = 8'h32;
  localparam logic [7:0] SPAN_DEFAULT = 8'h32;
  localparam logic [8:0] FACTOR_MIN = 9'h014;
  localparam logic [8:0] FACTOR_MAX = 9'h1F4;
  localparam logic [8:0] FACTOR_DEFAULT = 9'h064;
  localparam logic [3:0] RANGE_IDX_MAX = 4'hA;
  localparam logic [3:0] RANGE_IDX_100 = 4'hA;
  // range values in tenths: 0.3 0.5 1 3 5 10 15 20 25 50 100
  localparam logic [10:0][15:0] RANGE_TENTHS = {16'h03E8, 16'h01F4, 16'h00FA, 16'h00C8, 16'h0096,
    16'h0064, 16'h0032, 16'h001E, 16'h000A, 16'h0005, 16'h0003};
  // register byte offsets and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SETTINGS = 8'h04;
  localparam logic [7:0] REG_STATE = 8'h08;
  localparam logic [7:0] REG_MEAS = 8'h0C;
  localparam int CTRL_HALF_BIT = 0;
  localparam int CTRL_RESTORE_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MODE_NORMAL, MODE_MENU, MODE_STATUS, MODE_EDIT_SPAN, MODE_EDIT_TYPE,
    MODE_EDIT_RANGE, MODE_EDIT_FACTOR, MODE_MESSAGE
  } mode_t;

  typedef enum logic [1:0] {GAS_METHANE, GAS_HEAVY_HC, GAS_VOLUME, GAS_CO2} gas_t;

  typedef enum logic [3:0] {
    MSG_NONE, MSG_MENU_STATUS, MSG_MENU_SPAN, MSG_MENU_TYPE, MSG_MENU_FACTOR, MSG_STATUS_ITEM,
    MSG_EDIT_LEVEL, MSG_EDIT_TYPE, MSG_EDIT_RANGE, MSG_EDIT_FACTOR, MSG_LEVEL_SAVED,
    MSG_TYPE_SAVED, MSG_FACTOR_SAVED, MSG_RANGE_FIXED
  } msg_t;

  // display word seen by the text driver
  typedef struct packed {
    msg_t msg;
    logic [15:0] value;
    logic promptLeft;
    logic promptRight;
  } display_t;

  typedef struct packed {
    logic [TICK_W-1:0] prescale;
    logic tick;
    logic [1:0][1:0] sync;
    logic [1:0] stable;
    logic [1:0][MS_W-1:0] debCnt;
    logic [1:0][MS_W-1:0] holdMs;
    logic [1:0] fired;
    mode_t mode;
    mode_t retMode;
    logic [1:0] menu;
    logic [3:0] statusIdx;
    logic [MS_W-1:0] scrollMs;
    logic [2:0] scrollCount;
    logic [7:0] span;
    gas_t gasType;
    logic [3:0] rangeIdx;
    logic [8:0] factor;
    logic [8:0] editVal;
    logic halfRange;
    logic [15:0] measValue;
    logic awHave;
    logic wHave;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    display_t disp;
    logic programMode;
  } state_t;
endpackage : menu_ctrl_pkg

// *** sensor_setup_menu_controller.sv ***
// program-mode menu controller with two magnetic switches and an AXI4-Lite register slave
`timescale 1ns/10ps
module sensor_setup_menu_controller
  import menu_ctrl_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES,
  parameter int ENTRY_MS = ENTRY_HOLD_MS,
  parameter int ITEM_MS = ITEM_HOLD_MS,
  parameter int SAVE_MS = SAVE_HOLD_MS,
  parameter int RANGE_MS = RANGE_HOLD_MS,
  parameter int PROMPT_HOLD_MS = PROMPT_MS,
  parameter int DEBOUNCE_HOLD_MS = DEBOUNCE_MS,
  parameter int SCROLL_TIME_MS = SCROLL_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // magnetic switches, active high when the magnet is present
  input wire logic leftMagneticSwitch,
  input wire logic rightMagneticSwitch,
  // AXI4-Lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // display and mode
  output display_t display,
  output logic programMode
);

  // refuse parameters the counters cannot hold
  if (TICK_COUNT < 2 || TICK_COUNT >= (1 << TICK_W)) begin : g_tick_chk
    $error("TICK_COUNT out of range");
  end
  if (ENTRY_MS >= (1 << MS_W) || ITEM_MS <= PROMPT_HOLD_MS || SCROLL_TIME_MS < 1 || DEBOUNCE_HOLD_MS < 1)
  begin : g_ms_chk
    $error("hold or scroll time out of range");
  end

  state_t s;
  state_t n;

  // one clocked copy of the whole state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.span <= SPAN_DEFAULT;
      s.factor <= FACTOR_DEFAULT;
      s.rangeIdx <= RANGE_IDX_100;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // next-state logic
  always_comb begin
    logic [1:0] hit;
    logic [1:0] mom;
    logic [1:0] raw;
    logic [MS_W-1:0] thr;
    logic [7:0] lo;
    logic [7:0] hi;
    logic act;
    logic doWrite;
    hit = '0;
    mom = '0;
    raw = {rightMagneticSwitch, leftMagneticSwitch};
    thr = '0;
    act = 1'b0;
    doWrite = 1'b0;
    lo = s.halfRange ? SPAN_MIN_HALF : SPAN_MIN_FULL;
    hi = s.halfRange ? SPAN_MAX_HALF : SPAN_MAX_FULL;
    n = s;

    // free-running millisecond tick
    n.tick = 1'b0;
    if (s.prescale == TICK_W'(TICK_COUNT - 1)) begin
      n.prescale = '0;
      n.tick = 1'b1;
    end else begin
      n.prescale = s.prescale + 1'b1;
    end

    // hold threshold for the current mode
    case (s.mode)
      MODE_NORMAL: thr = MS_W'(ENTRY_MS);
      MODE_MENU: thr = MS_W'(ITEM_MS);
      MODE_EDIT_RANGE: thr = MS_W'(RANGE_MS);
      MODE_EDIT_SPAN, MODE_EDIT_TYPE, MODE_EDIT_FACTOR: thr = MS_W'(SAVE_MS);
      default: thr = {MS_W{1'b1}};
    endcase

    // synchronise, debounce and time each switch
    for (int i = 0; i < 2; i++) begin
      n.sync[i] = {s.sync[i][0], raw[i]};
      if (s.sync[i][1] == s.stable[i]) begin
        n.debCnt[i] = '0;
      end else if (s.tick) begin
        if (s.debCnt[i] >= MS_W'(DEBOUNCE_HOLD_MS - 1)) begin
          n.debCnt[i] = '0;
          n.stable[i] = s.sync[i][1];
          n.holdMs[i] = '0;
          n.fired[i] = 1'b0;
          mom[i] = s.stable[i] && !s.fired[i];
        end else begin
          n.debCnt[i] = s.debCnt[i] + 1'b1;
        end
      end
      if (s.stable[i] && !s.fired[i] && s.holdMs[i] >= thr) begin
        hit[i] = 1'b1;
        n.fired[i] = 1'b1;
      end else if (s.stable[i] && s.tick && s.holdMs[i] != {MS_W{1'b1}}) begin
        n.holdMs[i] = s.holdMs[i] + 1'b1;
      end
    end
    if (s.mode == MODE_NORMAL) begin
      hit[0] = 1'b0;
      mom = '0;
    end
    act = |s.stable || |mom;

    // scroll timer, cleared by switch activity
    if (act || s.mode == MODE_NORMAL) begin
      n.scrollMs = '0;
      n.scrollCount = '0;
    end else if (s.tick) begin
      if (s.scrollMs >= MS_W'(SCROLL_TIME_MS - 1)) begin
        n.scrollMs = '0;
        n.scrollCount = s.scrollCount + 1'b1;
      end else begin
        n.scrollMs = s.scrollMs + 1'b1;
      end
    end

    // menu state machine
    case (s.mode)
      MODE_NORMAL: begin
        if (hit[1]) begin
          n.mode = MODE_MENU;
          n.menu = 2'h0;
        end
      end
      MODE_MENU: begin
        if (mom[1]) begin
          n.menu = s.menu + 1'b1;
        end else if (mom[0]) begin
          n.menu = s.menu - 1'b1;
        end else if (|hit) begin
          n.editVal = '0;
          case (s.menu)
            2'h0: begin
              n.mode = MODE_STATUS;
              n.statusIdx = '0;
            end
            2'h1: begin
              n.mode = MODE_EDIT_SPAN;
              n.editVal = {1'b0, (s.span < lo) ? lo : (s.span > hi) ? hi : s.span};
            end
            2'h2: begin
              if (s.halfRange) begin
                n.mode = MODE_MESSAGE;
                n.retMode = MODE_MENU;
              end else begin
                n.mode = MODE_EDIT_TYPE;
                n.editVal = {7'h00, s.gasType};
              end
            end
            default: begin
              n.mode = MODE_EDIT_FACTOR;
              n.editVal = s.factor;
            end
          endcase
        end else if (s.scrollCount == 3'(TIMEOUT_SCROLLS)) begin
          n.mode = MODE_NORMAL;
        end
      end
      MODE_STATUS: begin
        if (s.tick && s.scrollMs >= MS_W'(SCROLL_TIME_MS - 1)) begin
          if (s.statusIdx == STATUS_LAST) begin
            n.mode = MODE_MENU;
          end else begin
            n.statusIdx = s.statusIdx + 1'b1;
          end
        end
      end
      MODE_EDIT_SPAN: begin
        if (mom[1] && s.editVal[7:0] < hi) begin
          n.editVal = s.editVal + 1'b1;
        end else if (mom[0] && s.editVal[7:0] > lo) begin
          n.editVal = s.editVal - 1'b1;
        end else if (|hit) begin
          n.span = s.editVal[7:0];
          n.mode = MODE_MESSAGE;
          n.retMode = MODE_MENU;
        end
      end
      MODE_EDIT_TYPE: begin
        if (mom[1]) begin
          n.editVal = {7'h00, s.editVal[1:0] + 2'h1};
        end else if (mom[0]) begin
          n.editVal = {7'h00, s.editVal[1:0] - 2'h1};
        end else if (|hit) begin
          n.gasType = gas_t'(s.editVal[1:0]);
          if (gas_t'(s.editVal[1:0]) != GAS_CO2) begin
            n.rangeIdx = RANGE_IDX_100;
          end
          n.mode = MODE_MESSAGE;
          n.retMode = MODE_EDIT_RANGE;
        end
      end
      MODE_EDIT_RANGE: begin
        if (s.gasType == GAS_CO2 && mom[1] && s.editVal[3:0] < RANGE_IDX_MAX) begin
          n.editVal = s.editVal + 1'b1;
        end else if (s.gasType == GAS_CO2 && mom[0] && s.editVal[3:0] != 4'h0) begin
          n.editVal = s.editVal - 1'b1;
        end else if (|hit) begin
          n.rangeIdx = s.editVal[3:0];
          n.mode = MODE_MENU;
        end
      end
      MODE_EDIT_FACTOR: begin
        if (mom[1] && s.editVal < FACTOR_MAX) begin
          n.editVal = s.editVal + 1'b1;
        end else if (mom[0] && s.editVal > FACTOR_MIN) begin
          n.editVal = s.editVal - 1'b1;
        end else if (|hit) begin
          n.factor = s.editVal;
          n.mode = MODE_MESSAGE;
          n.retMode = MODE_MENU;
        end
      end
      MODE_MESSAGE: begin
        if (s.tick && s.scrollMs >= MS_W'(SCROLL_TIME_MS - 1)) begin
          n.mode = s.retMode;
          n.editVal = {5'h00, s.rangeIdx};
        end
      end
      default: n.mode = MODE_NORMAL;
    endcase
    // edits and messages give up after the idle timeout; the status list runs to its end
    if (!(s.mode inside {MODE_NORMAL, MODE_MENU, MODE_STATUS}) && s.scrollCount == 3'(TIMEOUT_SCROLLS)) begin
      n.mode = MODE_NORMAL;
    end
    if (n.mode != s.mode) begin
      n.scrollMs = '0;
      n.scrollCount = '0;
    end

    // AXI4-Lite write channel
    if (awvalid && s.awready) begin
      n.awHave = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.wHave = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    doWrite = s.awHave && s.wHave && !s.bvalid;
    if (doWrite) begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case ({s.awAddr[7:2], 2'b00})
        REG_CTRL: begin
          if (s.wStrb[0]) begin
            n.halfRange = s.wData[CTRL_HALF_BIT];
            if (s.wData[CTRL_RESTORE_BIT]) begin
              n.span = SPAN_DEFAULT;
              n.gasType = GAS_METHANE;
              n.factor = FACTOR_DEFAULT;
              n.rangeIdx = RANGE_IDX_100;
            end
          end
        end
        REG_MEAS: begin
          if (s.wStrb[0]) n.measValue[7:0] = s.wData[7:0];
          if (s.wStrb[1]) n.measValue[15:8] = s.wData[15:8];
        end
        REG_SETTINGS, REG_STATE: n.bresp = RESP_OKAY;
        default: n.bresp = RESP_SLVERR;
      endcase
    end else if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    n.awready = !n.awHave && !n.bvalid;
    n.wready = !n.wHave && !n.bvalid;

    // AXI4-Lite read channel
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      case ({araddr[7:2], 2'b00})
        REG_CTRL: n.rdata[CTRL_HALF_BIT] = s.halfRange;
        REG_SETTINGS: n.rdata = {7'h00, s.factor, s.rangeIdx, 2'h0, s.gasType, s.span};
        REG_STATE: n.rdata = {15'h0000, s.programMode, s.stable, 2'h0, s.statusIdx, 2'h0, s.menu, s.mode};
        REG_MEAS: n.rdata = {16'h0000, s.measValue};
        default: n.rresp = RESP_SLVERR;
      endcase
    end else if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    n.arready = !n.rvalid;

    // display word from the next state
    n.programMode = n.mode != MODE_NORMAL;
    n.disp.promptLeft = n.mode == MODE_MENU && n.stable[0] && n.holdMs[0] >= MS_W'(PROMPT_HOLD_MS);
    n.disp.promptRight = n.mode != MODE_NORMAL && n.mode != MODE_STATUS && n.stable[1] &&
      n.holdMs[1] >= MS_W'(PROMPT_HOLD_MS);
    n.disp.value = {7'h00, n.editVal};
    case (n.mode)
      MODE_MENU: n.disp.msg = msg_t'(4'(MSG_MENU_STATUS) + {2'h0, n.menu});
      MODE_STATUS: begin
        n.disp.msg = MSG_STATUS_ITEM;
        case (n.statusIdx)
          4'h2: n.disp.value = {14'h0000, n.gasType};
          4'h3: n.disp.value = RANGE_TENTHS[n.rangeIdx];
          4'h5: n.disp.value = {8'h00, n.span};
          4'h8: n.disp.value = {7'h00, n.factor};
          default: n.disp.value = n.measValue;
        endcase
      end
      MODE_EDIT_SPAN: n.disp.msg = MSG_EDIT_LEVEL;
      MODE_EDIT_TYPE: n.disp.msg = MSG_EDIT_TYPE;
      MODE_EDIT_RANGE: begin
        n.disp.msg = MSG_EDIT_RANGE;
        n.disp.value = RANGE_TENTHS[n.editVal[3:0]];
      end
      MODE_EDIT_FACTOR: n.disp.msg = MSG_EDIT_FACTOR;
      MODE_MESSAGE: begin
        if (n.retMode == MODE_EDIT_RANGE) n.disp.msg = MSG_TYPE_SAVED;
        else if (n.menu == 2'h1) n.disp.msg = MSG_LEVEL_SAVED;
        else if (n.menu == 2'h2) n.disp.msg = MSG_RANGE_FIXED;
        else n.disp.msg = MSG_FACTOR_SAVED;
      end
      default: n.disp.msg = MSG_NONE;
    endcase
  end

  // outputs straight from the state flops
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign display = s.disp;
  assign programMode = s.programMode;

endmodule : sensor_setup_menu_controller

// *** menu_ctrl_sva.sv ***
// assertion checker for the program-mode menu controller
`timescale 1ns/10ps
module menu_ctrl_sva
  import menu_ctrl_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES,
  parameter int ENTRY_MS = ENTRY_HOLD_MS,
  parameter int ITEM_MS = ITEM_HOLD_MS,
  parameter int SCROLL_TIME_MS = SCROLL_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // switches
  input wire logic leftMagneticSwitch,
  input wire logic rightMagneticSwitch,
  // bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // display and mode
  input wire display_t display,
  input wire logic programMode
);
  localparam int ENTRY_CYC = (ENTRY_MS - 1) * TICK_COUNT;
  localparam int ITEM_CYC = (ITEM_MS - 1) * TICK_COUNT;
  localparam int IDLE_CYC = 3 * SCROLL_TIME_MS * TICK_COUNT;
  int leftCnt, rightCnt, idleCnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // raw hold lengths and quiet time on the pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      leftCnt <= 0;
      rightCnt <= 0;
      idleCnt <= 0;
    end else begin
      leftCnt <= leftMagneticSwitch ? leftCnt + 1 : 0;
      rightCnt <= rightMagneticSwitch ? rightCnt + 1 : 0;
      idleCnt <= (leftMagneticSwitch || rightMagneticSwitch) ? 0 : idleCnt + 1;
    end
  end

  // properties
  property p_entry;
    $rose(programMode) |-> rightCnt >= ENTRY_CYC && display.msg == MSG_MENU_STATUS;
  endproperty
  property p_idle_exit;
    $fell(programMode) |-> idleCnt >= IDLE_CYC;
  endproperty
  property p_open_entry;
    $past(display.msg) inside {MSG_MENU_SPAN, MSG_MENU_TYPE, MSG_MENU_FACTOR} &&
      display.msg inside {MSG_EDIT_LEVEL, MSG_EDIT_TYPE, MSG_EDIT_FACTOR, MSG_RANGE_FIXED}
      |-> rightCnt >= ITEM_CYC || leftCnt >= ITEM_CYC;
  endproperty
  property p_span_lim;
    display.msg == MSG_EDIT_LEVEL |-> display.value inside {[16'h0002:16'h005F]};
  endproperty
  property p_span_step;
    display.msg == MSG_EDIT_LEVEL && $past(display.msg) == MSG_EDIT_LEVEL && $changed(display.value)
      |-> (display.value - $past(display.value)) inside {16'h0001, 16'hFFFF};
  endproperty
  property p_level_saved;
    display.msg == MSG_LEVEL_SAVED && $past(display.msg) != MSG_LEVEL_SAVED |-> $past(display.msg) == MSG_EDIT_LEVEL;
  endproperty
  property p_range_after_type;
    display.msg == MSG_EDIT_RANGE && $past(display.msg) != MSG_EDIT_RANGE |-> $past(display.msg) == MSG_TYPE_SAVED;
  endproperty
  property p_range_lim;
    display.msg == MSG_EDIT_RANGE |-> display.value inside {[16'h0003:16'h03E8]};
  endproperty
  property p_factor_lim;
    display.msg == MSG_EDIT_FACTOR |-> display.value inside {[16'h0014:16'h01F4]};
  endproperty
  property p_status_end;
    $past(display.msg) == MSG_STATUS_ITEM && display.msg != MSG_STATUS_ITEM |-> display.msg == MSG_MENU_STATUS;
  endproperty
  property p_write_resp;
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
  endproperty
  property p_read_resp;
    arvalid && arready |=> rvalid && !arready;
  endproperty

  // assertions
  a_entry: assert property (p_entry) else $error("program mode entered without a full right hold");
  a_idle_exit: assert property (p_idle_exit) else $error("left program mode while switches active");
  a_open_entry: assert property (p_open_entry) else $error("entry opened without a long hold");
  a_span_lim: assert property (p_span_lim) else $error("span level out of limits");
  a_span_step: assert property (p_span_step) else $error("span level moved by more than one step");
  a_level_saved: assert property (p_level_saved) else $error("level saved not from span edit");
  a_range_after_type: assert property (p_range_after_type) else $error("range prompt not after type saved");
  a_range_lim: assert property (p_range_lim) else $error("range value out of table");
  a_factor_lim: assert property (p_factor_lim) else $error("gas factor out of limits");
  a_status_end: assert property (p_status_end) else $error("status list did not return to status entry");
  a_write_resp: assert property (p_write_resp) else $error("write response timing wrong");
  a_read_resp: assert property (p_read_resp) else $error("read response timing wrong");

  // main scenarios reached
  c_entry: cover property ($rose(programMode));
  c_saved: cover property (display.msg == MSG_LEVEL_SAVED);
  c_range: cover property (display.msg == MSG_EDIT_RANGE);
endmodule : menu_ctrl_sva

// *** operator_model.sv ***
// operator holding a magnet over either switch
`timescale 1ns/10ps
module operator_model #(
  parameter int TICK = 10
) (
  // clock
  input wire logic clk,
  // magnet present, high while held
  output logic leftMagneticSwitch,
  output logic rightMagneticSwitch
);
  // no magnet at start
  initial begin
    leftMagneticSwitch = 1'b0;
    rightMagneticSwitch = 1'b0;
  end

  // hold one magnet for ms milliseconds, then a quiet gap so the release settles
  task automatic press(input bit right, input int ms);
    @(posedge clk);
    if (right) rightMagneticSwitch <= 1'b1;
    else leftMagneticSwitch <= 1'b1;
    repeat (ms * TICK) @(posedge clk);
    rightMagneticSwitch <= 1'b0;
    leftMagneticSwitch <= 1'b0;
    repeat (5 * TICK) @(posedge clk);
  endtask : press
endmodule : operator_model

// *** tb_sensor_setup_menu_controller.sv ***
// testbench for the program-mode menu controller
`timescale 1ns/10ps
module tb_sensor_setup_menu_controller;
  import menu_ctrl_pkg::*;
  localparam int TK = 10;
  localparam int LIMIT = 40000;
  localparam int ENTRY_T = 50, OPEN_T = 20, SAVE_T = 15, SCROLL_T = 30;
  localparam logic [31:0] SET0 = {7'h00, FACTOR_DEFAULT, RANGE_IDX_100, 2'h0, GAS_METHANE, SPAN_DEFAULT};
  logic clk;
  logic rst_n;
  logic leftMagneticSwitch;
  logic rightMagneticSwitch;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, programMode;
  display_t display;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // design with shortened times
  sensor_setup_menu_controller #(.TICK_COUNT(TK), .ENTRY_MS(ENTRY_T), .ITEM_MS(OPEN_T), .SAVE_MS(SAVE_T),
    .RANGE_MS(10), .PROMPT_HOLD_MS(5), .DEBOUNCE_HOLD_MS(2), .SCROLL_TIME_MS(SCROLL_T)) dut (.clk(clk), .rst_n(rst_n),
    .leftMagneticSwitch(leftMagneticSwitch), .rightMagneticSwitch(rightMagneticSwitch), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .display(display), .programMode(programMode));

  // operator at the switches
  operator_model #(.TICK(TK)) op (.clk(clk), .leftMagneticSwitch(leftMagneticSwitch),
    .rightMagneticSwitch(rightMagneticSwitch));

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR t=%0t run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic pause(input int ms);
    repeat (ms * TK) @(posedge clk);
  endtask : pause

  // bus write: address and data offered together, each released when taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axiWrite

  // bus read
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axiRead

  // main sequence
  initial begin
    rst_n = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(programMode, 1'b0);
    chk(display.msg, MSG_NONE);
    axiRead(REG_SETTINGS, rd, rsp);
    chk(rd, SET0);
    axiRead(8'h40, rd, rsp);
    chk(rsp, RESP_SLVERR);
    axiWrite(REG_SETTINGS, 32'h0, rsp);
    chk(rsp, RESP_OKAY);
    axiWrite(8'h40, 32'h0, rsp);
    chk(rsp, RESP_SLVERR);
    axiRead(REG_SETTINGS, rd, rsp);
    chk(rd, SET0);
    $display("test registers done");
    // entry needs the right switch for the full hold
    op.press(0, 60);
    chk(programMode, 1'b0);
    op.press(1, 40);
    chk(programMode, 1'b0);
    op.press(1, 60);
    chk(programMode, 1'b1);
    chk(display.msg, MSG_MENU_STATUS);
    $display("test entry done");
    // neighbour entries both ways, with wrap
    op.press(1, 10);
    chk(display.msg, MSG_MENU_SPAN);
    op.press(0, 10);
    chk(display.msg, MSG_MENU_STATUS);
    op.press(0, 10);
    chk(display.msg, MSG_MENU_FACTOR);
    op.press(1, 10);
    op.press(1, 10);
    chk(display.msg, MSG_MENU_SPAN);
    $display("test navigation done");
    // span edit up to the limit, one step back, save
    op.press(1, 30);
    chk(display.msg, MSG_EDIT_LEVEL);
    chk(display.value, SPAN_DEFAULT);
    repeat (47) op.press(1, 10);
    chk(display.value, SPAN_MAX_FULL);
    op.press(0, 10);
    chk(display.value, SPAN_MAX_FULL - 8'h01);
    op.press(0, 20);
    chk(display.msg, MSG_LEVEL_SAVED);
    pause(30);
    chk(display.msg, MSG_MENU_SPAN);
    axiRead(REG_SETTINGS, rd, rsp);
    chk(rd[7:0], SPAN_MAX_FULL - 8'h01);
    $display("test span done");
    // half-range unit: span clamped, type and range locked
    axiWrite(REG_CTRL, 32'h1, rsp);
    op.press(1, 30);
    chk(display.value, SPAN_MAX_HALF);
    op.press(1, 10);
    chk(display.value, SPAN_MAX_HALF);
    op.press(0, 20);
    pause(30);
    op.press(1, 10);
    op.press(1, 30);
    chk(display.msg, MSG_RANGE_FIXED);
    pause(30);
    chk(display.msg, MSG_MENU_TYPE);
    axiWrite(REG_CTRL, 32'h0, rsp);
    $display("test half range done");
    // gas type cycles through four groupings, then carbon dioxide ranges
    op.press(1, 30);
    chk(display.msg, MSG_EDIT_TYPE);
    chk(display.value, GAS_METHANE);
    for (int i = 1; i < 8; i++) begin
      op.press(1, 10);
      chk(display.value, i % 4);
    end
    op.press(1, 20);
    chk(display.msg, MSG_TYPE_SAVED);
    pause(30);
    chk(display.msg, MSG_EDIT_RANGE);
    chk(display.value, RANGE_TENTHS[10]);
    op.press(0, 6);
    chk(display.value, RANGE_TENTHS[9]);
    op.press(1, 6);
    op.press(1, 6);
    chk(display.value, RANGE_TENTHS[10]);
    op.press(0, 6);
    op.press(0, 14);
    chk(display.msg, MSG_MENU_TYPE);
    axiRead(REG_SETTINGS, rd, rsp);
    chk(rd[15:8], {4'h9, 2'h0, GAS_CO2});
    $display("test type and range done");
    // factor edit, left at unity for a carbon dioxide unit
    op.press(1, 10);
    op.press(1, 30);
    chk(display.msg, MSG_EDIT_FACTOR);
    chk(display.value, FACTOR_DEFAULT);
    op.press(1, 10);
    chk(display.value, FACTOR_DEFAULT + 9'h001);
    op.press(0, 10);
    chk(display.value, FACTOR_DEFAULT);
    op.press(1, 20);
    chk(display.msg, MSG_FACTOR_SAVED);
    pause(30);
    chk(display.msg, MSG_MENU_FACTOR);
    pause(70);
    chk(programMode, 1'b1);
    pause(70);
    chk(programMode, 1'b0);
    $display("test factor and timeout done");
    // status list runs through, returns, and replays on a long hold
    op.press(1, 60);
    op.press(1, 30);
    chk(display.msg, MSG_STATUS_ITEM);
    pause(370);
    chk(display.msg, MSG_STATUS_ITEM);
    pause(60);
    chk(display.msg, MSG_MENU_STATUS);
    op.press(1, 30);
    chk(display.msg, MSG_STATUS_ITEM);
    wstrb <= 4'h1;
    axiWrite(REG_MEAS, 32'h0000ABCD, rsp);
    axiRead(REG_MEAS, rd, rsp);
    chk(rd, 32'h000000CD);
    axiWrite(REG_CTRL, 32'h00000002, rsp);
    axiRead(REG_SETTINGS, rd, rsp);
    chk(rd, SET0);
    $display("test status and defaults done");
    tally_and_finish();
  end
endmodule : tb_sensor_setup_menu_controller

bind sensor_setup_menu_controller menu_ctrl_sva #(.TICK_COUNT(TICK_COUNT), .ENTRY_MS(ENTRY_MS), .ITEM_MS(ITEM_MS),
  .SCROLL_TIME_MS(SCROLL_TIME_MS)) sva (.clk(clk), .rst_n(rst_n), .leftMagneticSwitch(leftMagneticSwitch),
  .rightMagneticSwitch(rightMagneticSwitch), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .display(display),
  .programMode(programMode));
